/* dv/hbd_core_tb.sv */
// self-checking bench of the half-bridge control block
`timescale 1ns/1ps
module hbd_core_tb;
  localparam int OL_CYC = 40;
  localparam int LIMIT = 40000;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sleep_n = 1'b1;
  logic uv = 1'b0;
  logic ov = 1'b0;
  logic [hbd_pkg::NUM_HB-1:0] t_warn = '0, t_shut = '0, i_over = '0, i_low = '0, i_cross = '0;
  logic sclk, sel_n, din, dout, dout_oe;
  logic dout_last = 1'b0;
  logic [hbd_pkg::NUM_HB-1:0] hs, ls;
  logic [15:0] r;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  // released reply line shows the inverse of its last driven level
  wire logic dout_w = dout_oe ? dout : ~dout_last;

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  // hang guard and last driven reply level
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (dout_oe)
      dout_last <= dout;
    if (cyc == LIMIT) begin
      error_cnt++;
      wrap_up();
    end
  end

  hbd_core #(.OL_DELAY_CYC(OL_CYC)) DUT (
    .clk_in(clk_in), .resetn_in(resetn_in), .inhibit_sleep_n_in(sleep_n),
    .vs_undervolt_in(uv), .vs_overvolt_in(ov), .temp_warn_in(t_warn),
    .temp_shutdown_in(t_shut), .overcurrent_in(i_over), .open_load_in(i_low),
    .cross_current_in(i_cross), .sclk_in(sclk), .chip_select_n_in(sel_n),
    .serial_in_in(din), .serial_out_out(dout), .serial_out_oe_out(dout_oe),
    .high_side_switch_out(hs), .low_side_switch_out(ls)
  );

  hbd_spi_master mst (
    .sclk_out(sclk), .sel_n_out(sel_n), .din_out(din), .dout_in(dout_w)
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_sw(input logic [9:0] eh, input logic [9:0] el);
    chk("high side", {6'h00, eh}, {6'h00, hs});
    chk("low side", {6'h00, el}, {6'h00, ls});
  endtask

  // settle past the edge so flags are read after they land
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic frame(input logic [15:0] c);
    mst.xfer({16'h0000, c}, 16, r);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // main sequence; waits of 300 cover the longest dead time
  initial begin
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_warn <= 10'h008;
    wait_clk(5);
    chk_sw(10'h000, 10'h000);
    frame(16'h0082);
    chk("first reply", 16'h0001, r);
    chk("reply enable", 16'h0000, {15'h0000, dout_oe});
    @(posedge clk_in);
    t_warn <= 10'h000;
    wait_clk(300);
    chk_sw(10'h001, 10'h000);
    // group 1 with its blank bits set on purpose
    frame(16'h58e0);
    chk("group 0 reply", 16'h0082, r);
    wait_clk(300);
    chk_sw(10'h001, 10'h040);
    frame(16'h4080);
    chk("group 1 reply", 16'h0080, r);
    // under- then overvoltage, settings must survive
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      uv <= (k == 0);
      ov <= (k == 1);
      wait_clk(10);
      chk_sw(10'h000, 10'h000);
      frame(16'h0082);
      chk("supply fail", 16'h4000, r);
      @(posedge clk_in);
      uv <= 1'b0;
      ov <= 1'b0;
      wait_clk(300);
      chk_sw(10'h001, 10'h040);
    end
    // overcurrent trip, refused short frame, daisy-chain clear
    @(posedge clk_in);
    i_over <= 10'h001;
    wait_clk(1100);
    @(posedge clk_in);
    i_over <= 10'h000;
    wait_clk(300);
    chk_sw(10'h000, 10'h040);
    frame(16'h0082);
    chk("overcurrent", 16'h8000, r);
    mst.xfer(32'h0000_8082, 15, r);
    wait_clk(300);
    chk_sw(10'h000, 10'h040);
    // odd length with the clear bit set in the last sixteen: must clear nothing
    mst.xfer(32'h0000_8082, 17, r);
    wait_clk(300);
    chk_sw(10'h000, 10'h040);
    mst.xfer(32'h0000_8082, 24, r);
    wait_clk(300);
    chk_sw(10'h001, 10'h040);
    frame(16'h0082);
    chk("cleared", 16'h0082, r);
    // cross current on bridge 6
    @(posedge clk_in);
    i_cross <= 10'h040;
    wait_clk(5);
    chk_sw(10'h001, 10'h000);
    @(posedge clk_in);
    i_cross <= 10'h000;
    frame(16'h4080);
    frame(16'h4080);
    chk("cross current", 16'h8000, r);
    frame(16'hc080);
    wait_clk(300);
    // open load, first flag only, then with shutdown enabled
    @(posedge clk_in);
    i_low <= 10'h040;
    wait_clk(OL_CYC + 20);
    chk_sw(10'h001, 10'h040);
    @(posedge clk_in);
    i_low <= 10'h000;
    frame(16'he080);
    chk("open load", 16'h2080, r);
    wait_clk(300);
    @(posedge clk_in);
    i_low <= 10'h040;
    wait_clk(OL_CYC + 20);
    @(posedge clk_in);
    i_low <= 10'h000;
    wait_clk(300);
    chk_sw(10'h001, 10'h000);
    // thermal shutdown holds until a status clear
    @(posedge clk_in);
    t_shut <= 10'h004;
    wait_clk(5);
    chk_sw(10'h000, 10'h000);
    @(posedge clk_in);
    t_shut <= 10'h000;
    wait_clk(300);
    chk_sw(10'h000, 10'h000);
    frame(16'h8082);
    wait_clk(300);
    chk_sw(10'h001, 10'h000);
    // sleep resets both control words and ignores the link
    @(posedge clk_in);
    sleep_n <= 1'b0;
    wait_clk(5);
    chk_sw(10'h000, 10'h000);
    frame(16'h4080);
    @(posedge clk_in);
    sleep_n <= 1'b1;
    wait_clk(300);
    chk_sw(10'h000, 10'h000);
    frame(16'h0000);
    chk("after sleep", 16'h0000, r);
    wrap_up();
  end
endmodule

/* dv/hbd_spi_master.sv */
// serial master model that drives the link pins of the half-bridge block
`timescale 1ns/1ps
module hbd_spi_master (
  // link pins toward the block
  output logic sclk_out,
  output logic sel_n_out,
  output logic din_out,
  // reply line from the block
  input wire logic dout_in
);
  // idle levels: select pulled high, clock and data pulled low
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    din_out = 1'b0;
  end
  // one frame of n bits, msb first, 125 ns link clock
  // clock stays low at both select edges and stands still between frames
  task automatic xfer(input logic [31:0] d, input int n, output logic [15:0] r);
    r = 16'h0000;
    // step off the sampling edge so the pins never race the input flops
    #1;
    sel_n_out = 1'b0;
    #125;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_out = 1'b1;
      din_out = d[i];
      #62.5;
      sclk_out = 1'b0;
      r = {r[14:0], dout_in};
      #62.5;
    end
    #62.5;
    sel_n_out = 1'b1;
    din_out = 1'b0;
    #500;
  endtask
endmodule

/* hw/hbd_core.sv */
// control, protection and serial slave logic of the ten half-bridge driver
`timescale 1ns/1ps
module hbd_core #(
  parameter int OL_DELAY_CYC = hbd_pkg::DOLD_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // supply monitors and sleep pin
  input wire logic inhibit_sleep_n_in,
  input wire logic vs_undervolt_in,
  input wire logic vs_overvolt_in,
  // per-bridge sensors
  input wire logic [hbd_pkg::NUM_HB-1:0] temp_warn_in,
  input wire logic [hbd_pkg::NUM_HB-1:0] temp_shutdown_in,
  input wire logic [hbd_pkg::NUM_HB-1:0] overcurrent_in,
  input wire logic [hbd_pkg::NUM_HB-1:0] open_load_in,
  input wire logic [hbd_pkg::NUM_HB-1:0] cross_current_in,
  // serial link
  input wire logic sclk_in,
  input wire logic chip_select_n_in,
  input wire logic serial_in_in,
  output logic serial_out_out,
  output logic serial_out_oe_out,
  // power stage gates
  output logic [hbd_pkg::NUM_HB-1:0] high_side_switch_out,
  output logic [hbd_pkg::NUM_HB-1:0] low_side_switch_out
);
  localparam int N = hbd_pkg::NUM_HB;
  localparam int PIN_W = 5 * N + 6;
  localparam int OC_W = $clog2(hbd_pkg::DSD_CYC + 1);
  localparam int OL_W = $clog2(OL_DELAY_CYC + 1);
  localparam logic [PIN_W-1:0] PIN_IDLE = {{(PIN_W - 2){1'b0}}, 2'h2}; // select high, clock low

  // two-flop synchronisers for every pin; only the second stage is read
  logic [PIN_W-1:0] pin_meta_r, pin_meta_nxt, pin_sync_r, pin_sync_nxt;
  always_comb begin
    pin_meta_nxt = {inhibit_sleep_n_in, vs_undervolt_in, vs_overvolt_in, temp_warn_in,
      temp_shutdown_in, overcurrent_in, open_load_in, cross_current_in,
      sclk_in, chip_select_n_in, serial_in_in};
    pin_sync_nxt = pin_meta_r;
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // idle link levels, so no false select edge follows reset
      pin_meta_r <= PIN_IDLE;
      pin_sync_r <= PIN_IDLE;
    end else begin
      pin_meta_r <= pin_meta_nxt;
      pin_sync_r <= pin_sync_nxt;
    end
  end

  logic inh_s, uv_s, ov_s, sclk_s, csn_s, sdi_s;
  logic [N-1:0] tw_s, tsd_s, oc_s, ol_s, cc_s;
  assign {inh_s, uv_s, ov_s, tw_s, tsd_s, oc_s, ol_s, cc_s, sclk_s, csn_s, sdi_s} = pin_sync_r;

  // previous link levels for edge finding
  logic sclk_d_r, csn_d_r;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_d_r <= 1'b0;
      csn_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      csn_d_r <= csn_s;
    end
  end

  logic sleep, supply_fail_flag, tw_any, sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign sleep = ~inh_s;
  assign supply_fail_flag = uv_s | ov_s;
  assign tw_any = |tw_s;
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign cs_fall = ~csn_s & csn_d_r;
  assign cs_rise = csn_s & ~csn_d_r;

  // serial shift engine
  hbd_pkg::hbd_spi_e state_r, state_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic out_r, out_nxt, first_r, first_nxt;
  logic [15:0] stat_word;
  hbd_pkg::hbd_cmd_s cmd;
  logic frame_ok;
  assign cmd = hbd_pkg::hbd_cmd_s'(shift_r);
  // whole bytes and at least one full word, else the frame is dropped
  assign frame_ok = (state_r == hbd_pkg::SPI_SHIFT) & cs_rise & cnt_r[4]
    & (cnt_r[2:0] == 3'h0);
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    first_nxt = first_r;
    if (sleep) begin
      state_nxt = hbd_pkg::SPI_IDLE;
      shift_nxt = '0;
      cnt_nxt = '0;
      out_nxt = 1'b0;
    end else begin
      unique case (state_r)
        hbd_pkg::SPI_IDLE: begin
          if (cs_fall) begin
            state_nxt = hbd_pkg::SPI_SHIFT;
            shift_nxt = stat_word;
            out_nxt = stat_word[15];
            cnt_nxt = '0;
            first_nxt = 1'b0;
          end
        end
        hbd_pkg::SPI_SHIFT: begin
          if (cs_rise) begin
            state_nxt = hbd_pkg::SPI_IDLE;
          end else begin
            // sample on falling, present next bit on rising
            if (sclk_fall) begin
              shift_nxt = {shift_r[14:0], sdi_s};
              cnt_nxt = (cnt_r == hbd_pkg::CNT_TOP) ? hbd_pkg::CNT_WRAP : cnt_r + 5'h01;
            end
            if (sclk_rise) begin
              out_nxt = shift_r[15];
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= hbd_pkg::SPI_IDLE;
      shift_r <= '0;
      cnt_r <= '0;
      out_r <= 1'b0;
      first_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
      first_r <= first_nxt;
    end
  end
  // output released outside frames so other slaves can share the line
  assign serial_out_out = out_r;
  assign serial_out_oe_out = (state_r == hbd_pkg::SPI_SHIFT);

  // control banks, read address and thermal shutdown latch
  hbd_pkg::hbd_cmd_s ctrl_r [2];
  hbd_pkg::hbd_cmd_s ctrl_nxt [2];
  logic rd_addr_r, rd_addr_nxt, tsd_r, tsd_nxt;
  logic [1:0] clr_grp;
  assign clr_grp[0] = frame_ok & cmd.clr & ~cmd.addr;
  assign clr_grp[1] = frame_ok & cmd.clr & cmd.addr;
  always_comb begin
    ctrl_nxt = ctrl_r;
    rd_addr_nxt = rd_addr_r;
    if (sleep) begin
      ctrl_nxt[0] = hbd_pkg::CTRL_RST;
      ctrl_nxt[1] = hbd_pkg::CTRL_RST;
      rd_addr_nxt = hbd_pkg::RD_ADDR_RST;
    end else if (frame_ok) begin
      if (cmd.addr) begin
        ctrl_nxt[1] = shift_r & hbd_pkg::CTRL1_MASK;
      end else begin
        ctrl_nxt[0] = shift_r & hbd_pkg::CTRL0_MASK;
      end
      rd_addr_nxt = cmd.addr;
    end
    // shutdown wins over a clear arriving in the same cycle
    tsd_nxt = (|tsd_s) | (tsd_r & ~(|clr_grp));
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_r[0] <= hbd_pkg::CTRL_RST;
      ctrl_r[1] <= hbd_pkg::CTRL_RST;
      rd_addr_r <= hbd_pkg::RD_ADDR_RST;
      tsd_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      rd_addr_r <= rd_addr_nxt;
      tsd_r <= tsd_nxt;
    end
  end

  logic global_off;
  assign global_off = sleep | supply_fail_flag | tsd_r;

  // per-bridge drive, dead time and fault latches
  logic [N-1:0] hs_v, ls_v, ocl_v, oll_v;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_hb
      localparam int G = (i < hbd_pkg::GRP0_HB) ? 0 : 1;
      localparam int K = (i < hbd_pkg::GRP0_HB) ? i : i - hbd_pkg::GRP0_HB;
      logic hs_r, hs_nxt, ls_r, ls_nxt, ocl_r, ocl_nxt, oll_r, oll_nxt, off_r, off_nxt;
      logic [hbd_pkg::DT_W-1:0] dt_r, dt_nxt;
      logic [OC_W-1:0] occ_r, occ_nxt;
      logic [OL_W-1:0] olc_r, olc_nxt;
      logic oc_trip, ol_trip, kill, en;
      assign oc_trip = (occ_r == OC_W'(hbd_pkg::DSD_CYC));
      assign ol_trip = (olc_r == OL_W'(OL_DELAY_CYC));
      assign kill = oc_trip | cc_s[i] | (ol_trip & ctrl_r[G].olsd);
      assign en = ctrl_r[G].act[K] & ~global_off & ~off_r & ~kill;
      always_comb begin
        dt_nxt = (dt_r != '0) ? dt_r - 1'b1 : dt_r;
        // drop at once, switch on only after the other side's dead time
        hs_nxt = hs_r & en & ctrl_r[G].dir[K];
        ls_nxt = ls_r & en & ~ctrl_r[G].dir[K];
        if (hs_r & ~hs_nxt) dt_nxt = hbd_pkg::DT_W'(hbd_pkg::DHL_CYC);
        if (ls_r & ~ls_nxt) dt_nxt = hbd_pkg::DT_W'(hbd_pkg::DLH_CYC);
        if (en & ctrl_r[G].dir[K] & ~hs_r & ~ls_r & (dt_r == '0)) hs_nxt = 1'b1;
        if (en & ~ctrl_r[G].dir[K] & ~hs_r & ~ls_r & (dt_r == '0)) ls_nxt = 1'b1;
        occ_nxt = ((hs_r | ls_r) & oc_s[i]) ? (oc_trip ? occ_r : occ_r + 1'b1) : '0;
        olc_nxt = (ls_r & ol_s[i]) ? (ol_trip ? olc_r : olc_r + 1'b1) : '0;
        // a new fault wins over a clear in the same cycle
        ocl_nxt = oc_trip | cc_s[i] | (ocl_r & ~clr_grp[G]);
        oll_nxt = ol_trip | (oll_r & ~clr_grp[G]);
        off_nxt = kill | (off_r & ~clr_grp[G]);
      end
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          hs_r <= 1'b0;
          ls_r <= 1'b0;
          dt_r <= '0;
          occ_r <= '0;
          olc_r <= '0;
          ocl_r <= 1'b0;
          oll_r <= 1'b0;
          off_r <= 1'b0;
        end else begin
          hs_r <= hs_nxt;
          ls_r <= ls_nxt;
          dt_r <= dt_nxt;
          occ_r <= occ_nxt;
          olc_r <= olc_nxt;
          ocl_r <= ocl_nxt;
          oll_r <= oll_nxt;
          off_r <= off_nxt;
        end
      end
      assign hs_v[i] = hs_r;
      assign ls_v[i] = ls_r;
      assign ocl_v[i] = ocl_r;
      assign oll_v[i] = oll_r;
    end
  endgenerate
  assign high_side_switch_out = hs_v;
  assign low_side_switch_out = ls_v;

  // status words report the real drive state, not the control word
  hbd_pkg::hbd_stat_s st0, st1, st_first;
  assign st0 = '{oc: |ocl_v[5:0], supply_fail_flag: supply_fail_flag, ol: |oll_v[5:0], act: hs_v[5:0] | ls_v[5:0],
    dir: hs_v[5:0], tw: tw_any};
  assign st1 = '{oc: |ocl_v[9:6], supply_fail_flag: supply_fail_flag, ol: |oll_v[9:6],
    act: {2'b00, hs_v[9:6] | ls_v[9:6]}, dir: {2'b00, hs_v[9:6]}, tw: tw_any};
  assign st_first = '{oc: 1'b0, supply_fail_flag: supply_fail_flag, ol: 1'b0, act: 6'h00, dir: 6'h00, tw: tw_any};
  assign stat_word = first_r ? st_first : (rd_addr_r ? st1 : st0);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_frame_end;
    (state_r == hbd_pkg::SPI_SHIFT) && cs_rise && !sleep;
  endsequence
  sequence s_frame_start;
    (state_r == hbd_pkg::SPI_IDLE) && cs_fall && !sleep;
  endsequence
  property p_sleep_off;
    sleep |=> (hs_v == '0) && (ls_v == '0) && (ctrl_r[0] == hbd_pkg::CTRL_RST);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep left a switch on");
  property p_psf_off;
    supply_fail_flag && !sleep && !frame_ok |=> (hs_v == '0) && (ls_v == '0) && $stable(ctrl_r[0]);
  endproperty
  a_psf_off: assert property (p_psf_off) else $error("supply fault left a switch on");
  property p_tsd_off;
    tsd_r |=> (hs_v == '0) && (ls_v == '0);
  endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("thermal shutdown left a switch on");
  property p_no_overlap;
    (hs_v & ls_v) == '0;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both switches of a bridge on");
  property p_dead_time;
    $fell(hs_v[0]) |-> !ls_v[0] [*8];
  endproperty
  a_dead_time: assert property (p_dead_time) else $error("low side on within dead time");
  property p_load_status;
    s_frame_start |=> (shift_r == $past(stat_word)) && serial_out_oe_out;
  endproperty
  a_load_status: assert property (p_load_status) else $error("status not loaded");
  property p_adopt;
    s_frame_end ##0 frame_ok ##0 !cmd.addr |=> ctrl_r[0] == ($past(shift_r) & hbd_pkg::CTRL0_MASK);
  endproperty
  a_adopt: assert property (p_adopt) else $error("control word not adopted");
  property p_release;
    s_frame_end |=> !serial_out_oe_out;
  endproperty
  a_release: assert property (p_release) else $error("serial output still driven");
  property p_bad_len;
    s_frame_end ##0 !frame_ok |=> $stable(ctrl_r[0]) && $stable(ctrl_r[1]) && $stable(rd_addr_r);
  endproperty
  a_bad_len: assert property (p_bad_len) else $error("short frame changed control");
  property p_oc_latch;
    g_hb[0].oc_trip |=> ocl_v[0] && g_hb[0].off_r && !hs_v[0] && !ls_v[0];
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("overcurrent not latched off");
endmodule

/* hw/hbd_pkg.sv */
// shared constants, layouts and states of the half-bridge control block
package hbd_pkg;
  // bridge counts, split across the two control/status words
  localparam int NUM_HB = 10;
  localparam int GRP0_HB = 6;
  localparam int GRP1_HB = 4;
  localparam int WORD_W = 16;
  // clock rate and switching/filter times in ns
  localparam int CLK_MHZ = 100;
  localparam int T_DSD_NS = 10000;
  localparam int T_DOLD_NS = 200000;
  localparam int T_DHL_NS = 1500;
  localparam int T_DLH_NS = 2500;
  // least times, rounded up to whole cycles
  localparam int DSD_CYC = (T_DSD_NS * CLK_MHZ + 999) / 1000;
  localparam int DOLD_CYC = (T_DOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int DHL_CYC = (T_DHL_NS * CLK_MHZ + 999) / 1000;
  localparam int DLH_CYC = (T_DLH_NS * CLK_MHZ + 999) / 1000;
  localparam int DT_W = 8;
  // writable bits of each control word; bit 0 and blanks are dropped
  localparam logic [15:0] CTRL0_MASK = 16'hfffe;
  localparam logic [15:0] CTRL1_MASK = 16'he79e;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic RD_ADDR_RST = 1'b0;
  // frame length bookkeeping: bit count wraps from 31 back to 16
  localparam logic [4:0] CNT_TOP = 5'h1f;
  localparam logic [4:0] CNT_WRAP = 5'h10;
  // command word layout
  typedef struct packed {
    logic clr;
    logic addr;
    logic olsd;
    logic [5:0] act;
    logic [5:0] dir;
    logic zero;
  } hbd_cmd_s;
  // status word layout
  typedef struct packed {
    logic oc;
    logic supply_fail_flag;
    logic ol;
    logic [5:0] act;
    logic [5:0] dir;
    logic tw;
  } hbd_stat_s;
  typedef enum logic [0:0] {
    SPI_IDLE = 1'b0,
    SPI_SHIFT = 1'b1
  } hbd_spi_e;
endpackage
